// ===== mbag_consts.svh
// register map, field positions, reset values of the address generation block
`ifndef MBAG_CONSTS_SVH
`define MBAG_CONSTS_SVH
`define MBAG_OFF_MODE 8'h00
`define MBAG_OFF_BREV 8'h04
`define MBAG_OFF_XSTART 8'h08
`define MBAG_OFF_XEND 8'h0C
`define MBAG_OFF_YSTART 8'h10
`define MBAG_OFF_YEND 8'h14
`define MBAG_OFF_STATUS 8'h18
`define MBAG_XSEL_LSB 0
`define MBAG_YSEL_LSB 4
`define MBAG_RSEL_LSB 8
`define MBAG_YEN_BIT 14
`define MBAG_XEN_BIT 15
`define MBAG_REN_BIT 15
`define MBAG_SEL_OFF 4'hF
`define MBAG_MODE_RST 16'h0FFF
`define MBAG_BREV_RST 16'h0000
`define MBAG_BUF_RST 16'h0000
`endif

// ===== mbag_pkg.sv
// types shared by the address generation block
package mbag_pkg;
  typedef enum logic [2:0] {
    AM_INDIRECT, AM_POST_INC, AM_POST_DEC, AM_PRE_INC, AM_PRE_DEC, AM_REG_OFFSET, AM_LIT_OFFSET
  } mbag_mode_t;
  typedef enum logic [1:0] {SP_X_READ, SP_X_WRITE, SP_Y} mbag_space_t;
  typedef struct packed {
    logic [15:0] mode_ctl;
    logic [15:0] brev_ctl;
    logic [15:0] x_start;
    logic [15:0] x_end;
    logic [15:0] y_start;
    logic [15:0] y_end;
    logic bus_pend;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] rdata;
    logic ea_valid;
    logic [15:0] ea;
    logic wb_en;
    logic [15:0] wb;
    logic ea_bitrev;
    logic ea_wrap;
    logic [15:0] wrap_count;
  } mbag_state_t;
endpackage

// ===== mbag_modulo.sv
// circular buffer boundary correction for one effective address
`timescale 1ns/1ps
module mbag_modulo
(
  input wire logic en,
  input wire logic word_only,
  input wire logic [15:0] addr,
  input wire logic [15:0] start_addr,
  input wire logic [15:0] end_addr,
  output logic [15:0] fixed_addr,
  output logic wrapped
);
  logic [15:0] len;

  // length wraps to zero for a full 64 KB buffer, which still corrects right modulo 2^16
  assign len = 16'(end_addr - start_addr + 16'h0001);

  // compare, not equality, so jumps past a limit still land inside
  always_comb
  begin
    fixed_addr = addr;
    wrapped = 1'b0;
    if (en && addr > end_addr)
    begin
      fixed_addr = 16'(addr - len);
      wrapped = 1'b1;
    end
    else if (en && addr < start_addr)
    begin
      fixed_addr = 16'(addr + len);
      wrapped = 1'b1;
    end
    if (en && word_only)
    begin
      fixed_addr[0] = 1'b0;
    end
  end
endmodule

// ===== mbag_top.sv
// modulo and bit-reversed address generation with AHB-Lite register slave
`timescale 1ns/1ps
`include "mbag_consts.svh"
module mbag_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic req_valid,
  input wire mbag_pkg::mbag_space_t req_space,
  input wire logic [3:0] req_reg,
  input wire mbag_pkg::mbag_mode_t req_mode,
  input wire logic req_byte,
  input wire logic [15:0] req_ptr,
  input wire logic [15:0] req_mod,
  output logic ea_valid,
  output logic [15:0] ea_addr,
  output logic ea_wb_en,
  output logic [15:0] ea_wb_data,
  output logic ea_bitrev,
  output logic ea_wrapped
);
  import mbag_pkg::*;

  mbag_state_t s_q;
  mbag_state_t s_d;
  logic is_x;
  logic [3:0] mod_sel;
  logic mod_bit;
  logic [3:0] rev_sel;
  logic rev_on;
  logic mod_on;
  logic is_pre;
  logic is_post;
  logic [15:0] target;
  logic [15:0] fixed;
  logic wrapped;
  logic [15:0] rev_next;
  logic [15:0] buf_start;
  logic [15:0] buf_end;
  logic addr_phase;
  logic [31:0] rd_mux;
  logic [31:0] wr_merged;

  // carry runs from the msb down: reverse both, add, reverse back
  function automatic logic [15:0] rev_add(input logic [15:0] ptr, input logic [14:0] pivot);
    logic [14:0] a;
    logic [14:0] b;
    logic [14:0] s;
    logic [14:0] r;
    for (int i = 0; i < 15; i++)
    begin
      a[i] = ptr[15 - i];
      b[i] = pivot[14 - i];
    end
    s = 15'(a + b);
    for (int i = 0; i < 15; i++)
    begin
      r[i] = s[14 - i];
    end
    return {r, 1'b0};
  endfunction

  // handshake outputs; the bus stalls while the clock enable freezes state
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign ea_valid = s_q.ea_valid;
  assign ea_addr = s_q.ea;
  assign ea_wb_en = s_q.wb_en;
  assign ea_wb_data = s_q.wb;
  assign ea_bitrev = s_q.ea_bitrev;
  assign ea_wrapped = s_q.ea_wrap;

  // unit selection: X read and X write share the X limits, Y has its own
  assign is_x = req_space != SP_Y;
  assign mod_sel = is_x ? s_q.mode_ctl[`MBAG_XSEL_LSB +: 4] : s_q.mode_ctl[`MBAG_YSEL_LSB +: 4];
  assign mod_bit = is_x ? s_q.mode_ctl[`MBAG_XEN_BIT] : s_q.mode_ctl[`MBAG_YEN_BIT];
  assign rev_sel = s_q.mode_ctl[`MBAG_RSEL_LSB +: 4];
  assign buf_start = is_x ? s_q.x_start : s_q.y_start;
  assign buf_end = is_x ? s_q.x_end : s_q.y_end;
  assign is_pre = req_mode == AM_PRE_INC || req_mode == AM_PRE_DEC;
  assign is_post = req_mode == AM_POST_INC || req_mode == AM_POST_DEC;

  // reversal only for word writes through the chosen pointer with increment modes
  assign rev_on = req_space == SP_X_WRITE && rev_sel != `MBAG_SEL_OFF
    && s_q.brev_ctl[`MBAG_REN_BIT] && req_reg == rev_sel
    && (req_mode == AM_PRE_INC || req_mode == AM_POST_INC) && !req_byte;

  // any working register but 15 may be the circular pointer; reversal masks modulo in X write
  assign mod_on = mod_sel != `MBAG_SEL_OFF && mod_bit && req_reg == mod_sel
    && !rev_on;

  // pivot is a word count, so it adds above bit 0 of the byte address
  assign rev_next = rev_add(req_ptr, s_q.brev_ctl[14:0]);

  // address before correction: indirect uses the pointer as is
  assign target = req_mode == AM_INDIRECT ? req_ptr : 16'(req_ptr + req_mod);

  mbag_modulo u_modulo
  (
    .en(mod_on),
    .word_only(!is_x),
    .addr(target),
    .start_addr(buf_start),
    .end_addr(buf_end),
    .fixed_addr(fixed),
    .wrapped(wrapped)
  );

  // bus bookkeeping
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_merged = s_q.bus_pend && s_q.bus_wr ? hwdata : 32'h00000000;

  // read data is sampled in the address phase; a write still in its data phase is forwarded
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (haddr[7:0])
      `MBAG_OFF_MODE: rd_mux = {16'h0000, s_q.mode_ctl};
      `MBAG_OFF_BREV: rd_mux = {16'h0000, s_q.brev_ctl};
      `MBAG_OFF_XSTART: rd_mux = {16'h0000, s_q.x_start};
      `MBAG_OFF_XEND: rd_mux = {16'h0000, s_q.x_end};
      `MBAG_OFF_YSTART: rd_mux = {16'h0000, s_q.y_start};
      `MBAG_OFF_YEND: rd_mux = {16'h0000, s_q.y_end};
      `MBAG_OFF_STATUS: rd_mux = {s_q.wrap_count, 14'h0000, s_q.ea_wrap, s_q.ea_bitrev};
      default: rd_mux = 32'h00000000;
    endcase
    if (s_q.bus_pend && s_q.bus_wr && s_q.bus_addr == haddr[7:0]
      && haddr[7:0] != `MBAG_OFF_STATUS && haddr[31:8] == 24'h000000 && rd_mux != 32'h00000000
      || s_q.bus_pend && s_q.bus_wr && s_q.bus_addr == haddr[7:0]
      && haddr[7:0] < `MBAG_OFF_STATUS && haddr[1:0] == 2'h0)
    begin
      rd_mux = {16'h0000, wr_merged[15:0]};
    end
    if (haddr[31:8] != 24'h000000)
    begin
      rd_mux = 32'h00000000;
    end
  end

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    // write data phase; unmapped and status offsets ignore the write
    if (s_q.bus_pend && s_q.bus_wr)
    begin
      unique case (s_q.bus_addr)
        `MBAG_OFF_MODE: s_d.mode_ctl = hwdata[15:0];
        `MBAG_OFF_BREV: s_d.brev_ctl = hwdata[15:0];
        `MBAG_OFF_XSTART: s_d.x_start = hwdata[15:0];
        `MBAG_OFF_XEND: s_d.x_end = hwdata[15:0];
        `MBAG_OFF_YSTART: s_d.y_start = hwdata[15:0];
        `MBAG_OFF_YEND: s_d.y_end = hwdata[15:0];
        default: s_d.bus_pend = 1'b0;
      endcase
    end
    // address phase
    s_d.bus_pend = addr_phase;
    s_d.bus_wr = addr_phase && hwrite;
    s_d.bus_addr = haddr[31:8] == 24'h000000 ? haddr[7:0] : 8'hFF;
    if (addr_phase && !hwrite)
    begin
      s_d.rdata = rd_mux;
    end
    // address generation, one result per request, one cycle later
    s_d.ea_valid = req_valid;
    s_d.wb_en = 1'b0;
    s_d.ea_bitrev = 1'b0;
    s_d.ea_wrap = 1'b0;
    if (req_valid)
    begin
      s_d.ea = fixed;
      s_d.wb = fixed;
      s_d.ea_wrap = wrapped;
      unique case (req_mode)
        AM_INDIRECT: s_d.ea = req_ptr;
        AM_POST_INC, AM_POST_DEC:
        begin
          s_d.ea = req_ptr;
          s_d.wb_en = 1'b1;
        end
        AM_PRE_INC, AM_PRE_DEC: s_d.wb_en = 1'b1;
        AM_REG_OFFSET, AM_LIT_OFFSET: s_d.wb_en = 1'b0;
        default: s_d.ea = req_ptr;
      endcase
      if (rev_on)
      begin
        // mode increment ignored, bit 0 forced clear
        s_d.ea_bitrev = 1'b1;
        s_d.ea_wrap = 1'b0;
        s_d.wb = rev_next;
        s_d.ea = is_pre ? rev_next : {req_ptr[15:1], 1'b0};
      end
      if (wrapped)
      begin
        s_d.wrap_count = 16'(s_q.wrap_count + 16'h0001);
      end
    end
  end

  // whole state held while the clock enable is low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.mode_ctl <= `MBAG_MODE_RST;
      s_q.brev_ctl <= `MBAG_BREV_RST;
      s_q.x_start <= `MBAG_BUF_RST;
      s_q.x_end <= `MBAG_BUF_RST;
      s_q.y_start <= `MBAG_BUF_RST;
      s_q.y_end <= `MBAG_BUF_RST;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // x and y enables: select 15 or a clear enable bit leaves addresses alone
  a_xmod_off_sel: assert property (
    ce && req_valid && is_x && s_q.mode_ctl[3:0] == 4'hF |=> !ea_wrapped)
    else $error("x modulo with select 15");
  a_xmod_off_en: assert property (
    ce && req_valid && is_x && !s_q.mode_ctl[15] |=> !ea_wrapped)
    else $error("x modulo while disabled");
  a_ymod_off_en: assert property (
    ce && req_valid && req_space == SP_Y && !s_q.mode_ctl[14] |=> !ea_wrapped)
    else $error("y modulo while disabled");
  a_ymod_off_sel: assert property (
    ce && req_valid && req_space == SP_Y && s_q.mode_ctl[7:4] == 4'hF |=> !ea_wrapped)
    else $error("y modulo with select 15");

  // limits found by compares, so a jump past either limit still gets corrected
  a_wrap_high: assert property (
    ce && req_valid && mod_on && target > buf_end |=> ea_wrapped)
    else $error("overshoot past end not corrected");
  a_wrap_low: assert property (
    ce && req_valid && mod_on && target < buf_start |=> ea_wrapped)
    else $error("undershoot past start not corrected");
  a_wrap_in_range: assert property (
    ce && req_valid && mod_on && is_post && buf_start <= buf_end
    |=> ea_wb_data >= $past(buf_start) && ea_wb_data <= $past(buf_end))
    else $error("wrapped pointer out of buffer");
  a_wrap_value: assert property (
    ce && req_valid && mod_on && is_x && is_pre && target > buf_end
    |=> ea_addr == 16'($past(target) + $past(buf_start) - $past(buf_end) - 16'h0001))
    else $error("wrap lands off start plus overshoot");

  // pointer write-back only for pre and post modify
  a_offset_no_wb: assert property (
    ce && req_valid && (req_mode == AM_REG_OFFSET || req_mode == AM_LIT_OFFSET)
    |=> ea_valid && !ea_wb_en)
    else $error("offset mode wrote back pointer");
  a_modify_wb: assert property (
    ce && req_valid && (is_pre || is_post) |=> ea_valid && ea_wb_en)
    else $error("modify mode lost write-back");

  // reversal is confined to word writes with increment modes
  a_rev_only_xw: assert property (
    ce && req_valid && req_space != SP_X_WRITE |=> !ea_bitrev)
    else $error("bit reversal outside x write");
  a_rev_off_sel: assert property (
    ce && req_valid && s_q.mode_ctl[11:8] == 4'hF |=> !ea_bitrev)
    else $error("bit reversal with select 15");
  a_rev_even: assert property (
    ea_valid && ea_bitrev |-> !ea_addr[0] && !ea_wb_data[0])
    else $error("reversed address odd");
  a_rev_byte_lin: assert property (
    ce && req_valid && req_byte |=> !ea_bitrev)
    else $error("byte access reversed");
  a_rev_dec_lin: assert property (
    ce && req_valid && (req_mode == AM_POST_DEC || req_mode == AM_PRE_DEC) |=> !ea_bitrev)
    else $error("decrement access reversed");

  // reversed update ignores the mode step and forces bit 0 clear
  a_rev_post_ea: assert property (
    ce && req_valid && rev_on && req_mode == AM_POST_INC
    |=> ea_addr == {$past(req_ptr[15:1]), 1'b0})
    else $error("post reversed ea wrong");
  a_rev_pre_ea: assert property (
    ce && req_valid && rev_on && req_mode == AM_PRE_INC |=> ea_addr == ea_wb_data)
    else $error("pre reversed ea differs from new pointer");

  // both enabled: reversal wins in x write, x read keeps its modulo
  a_rev_wins_xw: assert property (
    ce && req_valid && rev_on && s_q.mode_ctl[15] |=> ea_bitrev && !ea_wrapped)
    else $error("modulo not masked by reversal");
  a_xread_keeps_mod: assert property (
    ce && req_valid && req_space == SP_X_READ && s_q.brev_ctl[15] && mod_on
    && target > buf_end |=> ea_wrapped && !ea_bitrev)
    else $error("x read modulo lost with reversal on");

  // y space modulo works in words
  a_ymod_word: assert property (
    ce && req_valid && req_space == SP_Y && mod_on |=> !ea_wb_data[0])
    else $error("y modulo address odd");

  // register writes land, and the limits come from them
  a_mode_write: assert property (
    ce && s_q.bus_pend && s_q.bus_wr && s_q.bus_addr == `MBAG_OFF_MODE
    |=> s_q.mode_ctl == $past(hwdata[15:0]))
    else $error("mode register write lost");
  a_xstart_write: assert property (
    ce && s_q.bus_pend && s_q.bus_wr && s_q.bus_addr == `MBAG_OFF_XSTART
    |=> s_q.x_start == $past(hwdata[15:0]))
    else $error("x start register write lost");

  // clock enable freezes everything; a result follows each accepted request
  a_ce_freeze: assert property (
    !ce |=> $stable(ea_addr) && $stable(hrdata))
    else $error("state moved with clock enable low");
  a_ea_answer: assert property (
    ce && req_valid |=> ea_valid)
    else $error("request without a result");
  a_ea_pulse: assert property (
    ce && !req_valid |=> !ea_valid)
    else $error("result valid without a request");

  c_x_wrap: cover property (ce && req_valid && is_x && wrapped);
  c_y_wrap: cover property (ce && req_valid && req_space == SP_Y && wrapped);
  c_rev_pre: cover property (ce && req_valid && rev_on && is_pre);
  c_both_en: cover property (ce && req_valid && rev_on && s_q.mode_ctl[15]);
  c_ce_stall: cover property (!ce && req_valid);
endmodule

// ===== mbag_core_model.sv
// core decode model issuing effective address requests
`timescale 1ns/1ps
module mbag_core_model
(
  input wire logic hclk,
  output logic req_valid,
  output mbag_pkg::mbag_space_t req_space,
  output logic [3:0] req_reg,
  output mbag_pkg::mbag_mode_t req_mode,
  output logic req_byte,
  output logic [15:0] req_ptr,
  output logic [15:0] req_mod
);
  import mbag_pkg::*;
  initial
  begin
    req_valid = 1'b0;
    req_space = SP_X_READ;
    req_reg = 4'hF;
    req_mode = AM_INDIRECT;
    req_byte = 1'b0;
    req_ptr = 16'h0000;
    req_mod = 16'h0000;
  end
  // one-cycle pulse; operands scrambled after so stale values never match
  task automatic issue(input mbag_space_t s, input logic [3:0] r, input mbag_mode_t m,
    input logic b, input logic [15:0] p, input logic [15:0] d);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_space <= s;
    req_reg <= r;
    req_mode <= m;
    req_byte <= b;
    req_ptr <= p;
    req_mod <= d;
    @(posedge hclk);
    req_valid <= 1'b0;
    req_ptr <= ~p;
    req_mod <= ~d;
  endtask
endmodule

// ===== mbag_top_bench.sv
// register and address generation tests of the block
`timescale 1ns/1ps
module mbag_top_bench;
  import mbag_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ce;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic req_valid, req_byte, ea_valid, ea_wb_en, ea_bitrev, ea_wrapped;
  mbag_space_t req_space;
  mbag_mode_t req_mode;
  logic [3:0] req_reg;
  logic [15:0] req_ptr, req_mod, ea_addr, ea_wb_data;
  // byte addresses of word offsets 0, 8, 4, 12, 2, 10 in reversed order
  logic [15:0] seq [6] = '{16'h0800, 16'h0810, 16'h0808, 16'h0818, 16'h0804, 16'h0814};
  int fails, n_checks, cyc;
  mbag_top u_mbag_top (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .req_valid(req_valid), .req_space(req_space), .req_reg(req_reg), .req_mode(req_mode),
    .req_byte(req_byte), .req_ptr(req_ptr), .req_mod(req_mod), .ea_valid(ea_valid),
    .ea_addr(ea_addr), .ea_wb_en(ea_wb_en), .ea_wb_data(ea_wb_data),
    .ea_bitrev(ea_bitrev), .ea_wrapped(ea_wrapped));
  mbag_core_model u_mbag_core_model (.hclk(hclk), .req_valid(req_valid),
    .req_space(req_space), .req_reg(req_reg), .req_mode(req_mode), .req_byte(req_byte),
    .req_ptr(req_ptr), .req_mod(req_mod));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the roughly 160 cycles the tests need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // issue a request and compare the one-cycle answer
  task automatic core(input mbag_space_t s, input logic [3:0] r, input mbag_mode_t m,
    input logic b, input logic [15:0] pt, input logic [15:0] d, input logic [15:0] ea,
    input logic we, input logic [15:0] wb, input logic rv, input logic wr);
    u_mbag_core_model.issue(s, r, m, b, pt, d);
    #1;
    chk("ea_valid", 1, ea_valid);
    chk("ea_addr", ea, ea_addr);
    chk("ea_wb_en", we, ea_wb_en);
    if (we) chk("ea_wb_data", wb, ea_wb_data);
    chk("ea_bitrev", rv, ea_bitrev);
    chk("ea_wrapped", wr, ea_wrapped);
    // result flags stand for one cycle only
    @(posedge hclk);
    #1;
    chk("ea_valid drop", 0, ea_valid);
    chk("ea_wb_en drop", 0, ea_wb_en);
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, fails, n_checks, cyc} = '0;
    ce = 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, status and unmapped place
    for (int a = 0; a < 32; a += 4)
    begin
      bus(0, a, 0);
      chk("reset read", (a == 0) ? 32'h0FFF : 32'h0, rd);
    end
    bus(1, 8'h18, 32'hFFFF);
    bus(0, 8'h18, 0);
    chk("status ro", 0, rd);
    bus(1, 8'h1C, 32'hFFFF);
    bus(0, 8'h1C, 0);
    chk("unmapped", 0, rd);
    bus(1, 8'h08, 32'h1000);
    bus(1, 8'h0C, 32'h100F);
    bus(0, 8'h0C, 0);
    chk("x_end", 32'h100F, rd);
    bus(1, 8'h00, 32'h8FF5);
    core(SP_X_READ, 5, AM_POST_INC, 0, 16'h100E, 16'h0004, 16'h100E, 1,
      16'h1002, 0, 1);
    core(SP_X_WRITE, 5, AM_PRE_DEC, 0, 16'h1000, 16'hFFFE, 16'h100E, 1, 16'h100E, 0, 1);
    core(SP_X_READ, 5, AM_REG_OFFSET, 0, 16'h100E, 16'h0004, 16'h1002, 0, 0, 0, 1);
    core(SP_X_READ, 6, AM_PRE_INC, 0, 16'h100E, 16'h0004, 16'h1012, 1, 16'h1012, 0, 0);
    bus(1, 8'h00, 32'h8FFF);
    core(SP_X_READ, 15, AM_PRE_INC, 0, 16'h100E, 16'h0004, 16'h1012, 1, 16'h1012, 0, 0);
    bus(1, 8'h00, 32'h0FF5);
    core(SP_X_READ, 5, AM_PRE_INC, 0, 16'h100E, 16'h0004, 16'h1012, 1, 16'h1012, 0, 0);
    bus(1, 8'h10, 32'h2000);
    bus(1, 8'h14, 32'h201F);
    bus(1, 8'h00, 32'h4F3F);
    core(SP_Y, 3, AM_PRE_INC, 0, 16'h201E, 16'h0002, 16'h2000, 1, 16'h2000, 0, 1);
    core(SP_Y, 3, AM_PRE_INC, 0, 16'h2001, 16'h0002, 16'h2002, 1, 16'h2002, 0, 0);
    bus(1, 8'h00, 32'h0F3F);
    core(SP_Y, 3, AM_PRE_INC, 0, 16'h201E, 16'h0002, 16'h2020, 1, 16'h2020, 0, 0);
    // 16-word buffer at an aligned base, pivot of half its size
    bus(1, 8'h00, 32'h04FF);
    bus(1, 8'h04, 32'h8008);
    for (int i = 0; i < 5; i++)
    begin
      core(SP_X_WRITE, 4, AM_POST_INC, 0, seq[i], 16'h0002, seq[i], 1,
        seq[i + 1], 1, 0);
    end
    core(SP_X_WRITE, 4, AM_PRE_INC, 0, 16'h0801, 16'h0002, 16'h0810, 1, 16'h0810, 1, 0);
    core(SP_X_WRITE, 4, AM_POST_INC, 1, 16'h0800, 16'h0001, 16'h0800, 1, 16'h0801, 0, 0);
    core(SP_X_WRITE, 4, AM_POST_DEC, 0, 16'h0804, 16'hFFFE, 16'h0804, 1, 16'h0802, 0, 0);
    core(SP_X_READ, 4, AM_POST_INC, 0, 16'h0800, 16'h0002, 16'h0800, 1, 16'h0802, 0, 0);
    core(SP_X_WRITE, 5, AM_POST_INC, 0, 16'h0800, 16'h0002, 16'h0800, 1, 16'h0802, 0, 0);
    bus(1, 8'h04, 32'h0008);
    core(SP_X_WRITE, 4, AM_POST_INC, 0, 16'h0800, 16'h0002, 16'h0800, 1, 16'h0802, 0, 0);
    // both enabled on purpose to see which wins
    bus(1, 8'h08, 32'h0800);
    bus(1, 8'h0C, 32'h081F);
    bus(1, 8'h04, 32'h8008);
    bus(1, 8'h00, 32'h84F4);
    core(SP_X_WRITE, 4, AM_POST_INC, 0, 16'h0818, 16'h0002, 16'h0818, 1, 16'h0804, 1, 0);
    core(SP_X_READ, 4, AM_PRE_INC, 0, 16'h081E, 16'h0004, 16'h0802, 1, 16'h0802, 0, 1);
    // clock enable low: a request is lost and the bus stalls
    ce <= 1'b0;
    u_mbag_core_model.issue(SP_X_READ, 4, AM_PRE_INC, 0, 16'h081E, 16'h0004);
    #1;
    chk("frozen ea_valid", 0, ea_valid);
    chk("stall hreadyout", 0, hreadyout);
    @(posedge hclk);
    ce <= 1'b1;
    // five wraps so far; the frozen request must not count
    bus(0, 8'h18, 0);
    chk("wrap count", 32'h00050000, rd);
    chk("hresp", 0, hresp);
    report_and_stop();
  end
endmodule
